// ===== src/ebw_pkg.sv
package ebw_pkg;

  // ****************************************
  // register map (byte offsets)
  // ****************************************
  localparam logic [7:0] EBW_OFS_CTRL = 8'h00;
  localparam logic [7:0] EBW_OFS_STATUS = 8'h04;
  localparam logic [7:0] EBW_OFS_ADDR = 8'h08;
  localparam logic [7:0] EBW_OFS_WDATA = 8'h0C;
  localparam logic [7:0] EBW_OFS_TIMING = 8'h10;
  localparam logic [7:0] EBW_OFS_RDATA = 8'h14;

  // ****************************************
  // field positions
  // ****************************************
  localparam int EBW_CTRL_START = 0;
  localparam int EBW_CTRL_RNW = 1;
  localparam int EBW_STAT_BUSY = 0;
  localparam int EBW_STAT_DONE = 1;
  localparam int EBW_STAT_WCNT = 8;
  localparam int EBW_TIM_AB = 0;
  localparam int EBW_TIM_C = 1;
  localparam int EBW_TIM_D = 3;
  localparam int EBW_TIM_E = 4;
  localparam int EBW_TIM_F = 9;
  localparam int EBW_TIM_RDY_EN = 11;
  localparam int EBW_TIM_RDY_POL = 12;
  localparam int EBW_TIM_RDY_ASYNC = 13;

  // ****************************************
  // reset values and responses
  // ****************************************
  localparam logic [15:0] EBW_ADDR_RST = 16'h0000;
  localparam logic [15:0] EBW_WDATA_RST = 16'h0000;
  localparam logic [15:0] EBW_TIMING_RST = 16'h0000;
  localparam logic [1:0] EBW_RESP_OKAY = 2'h0;
  localparam logic [1:0] EBW_RESP_SLVERR = 2'h2;

  // ****************************************
  // bus cycle phases
  // ****************************************
  typedef enum logic [6:0] {
    EBW_PH_IDLE = 7'h01,
    EBW_PH_AB = 7'h02,
    EBW_PH_C = 7'h04,
    EBW_PH_D = 7'h08,
    EBW_PH_E = 7'h10,
    EBW_PH_RDY = 7'h20,
    EBW_PH_F = 7'h40
  } ebw_ph_e;

  // external bus outputs, all registered
  typedef struct packed {
    logic [15:0] addr;
    logic [15:0] dout;
    logic dout_oe;
    logic rd_n;
    logic wr_n;
    logic cs_n;
    logic ale;
    logic reference_clock_output;
  } ebw_pins_s;

  localparam ebw_pins_s EBW_PINS_RST = '{addr: 16'h0000, dout: 16'h0000, dout_oe: 1'b0,
    rd_n: 1'b1, wr_n: 1'b1, cs_n: 1'b1, ale: 1'b0, reference_clock_output: 1'b0};

endpackage

// ===== src/ebw_sync.sv
module ebw_sync #(
  parameter int WIDTH = 1,
  parameter int STAGES = 2
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);
  import ebw_pkg::*;

  typedef struct packed {
    logic [STAGES-1:0][WIDTH-1:0] chain;
  } ebw_sync_s;

  ebw_sync_s st_q;
  ebw_sync_s st_d;

  always_comb begin
    st_d = st_q;
    st_d.chain[0] = din;
    for (int i = 1; i < STAGES; i++) begin
      st_d.chain[i] = st_q.chain[i-1];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q <= '0;
    end else if (ce) begin
      st_q <= st_d;
    end
  end

  assign dout = st_q.chain[STAGES-1];

  // ****************************************
  // assertions
  // ****************************************
  a_sync_latency: assert property (@(posedge aclk) disable iff (!aresetn)
    (ce && $past(ce) && $past(ce, 2) && $past(aresetn, 2)) |-> dout == $past(din, 2))
    else $error("synchronizer output does not follow input by two stages");

endmodule

// ===== src/ebw_ctrl.sv
// Overview of operation
// - read data are captured on the edge that ends the read strobe.
// - address changes before read strobe end cannot alter captured read data.
// - responder stretches a cycle via the handshake; the controller extends it.
// - handshake active polarity is selectable by software.
// - synchronous handshake mode gives the shortest possible cycle.
// - asynchronous mode adds two synchronizer stages and at least one wait state.
// - inactive handshake at a sample point inserts one wait state.
// - active handshake at a sample point ends the bus cycle.
// - sample points differ by mode; sampled only after programmed access units.
// - five phases; access 1 to 32 units, command delay and hold 0 to 3.
//
// The AXI4-Lite slave port and the placing of the registers were chosen for this implementation.
module ebw_ctrl (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic ext_ready,
  input wire logic [15:0] ext_din,
  output ebw_pkg::ebw_pins_s ext_bus
);
  import ebw_pkg::*;

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    ebw_ph_e ph;
    logic [4:0] cnt;
    logic [7:0] wcnt;
    logic rnw;
    logic [15:0] cfg;
    logic go;
    logic done;
    ebw_pins_s pins;
    logic [15:0] rcap;
    logic [15:0] addr_r;
    logic [15:0] wdat_r;
    logic [15:0] tim_r;
    logic ctl_rnw;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic aw_have;
    logic w_have;
    logic [7:0] waddr;
    logic [31:0] wdat;
    logic [3:0] wstrb;
  } ebw_st_s;

  localparam ebw_st_s ST_RST = '{ph: EBW_PH_IDLE, cnt: 5'h00, wcnt: 8'h00, rnw: 1'b0,
    cfg: EBW_TIMING_RST, go: 1'b0, done: 1'b0, pins: EBW_PINS_RST, rcap: 16'h0000,
    addr_r: EBW_ADDR_RST, wdat_r: EBW_WDATA_RST, tim_r: EBW_TIMING_RST, ctl_rnw: 1'b0,
    awready: 1'b1, wready: 1'b1, bvalid: 1'b0, bresp: EBW_RESP_OKAY, arready: 1'b1,
    rvalid: 1'b0, rresp: EBW_RESP_OKAY, rdata: 32'h0000_0000, aw_have: 1'b0,
    w_have: 1'b0, waddr: 8'h00, wdat: 32'h0000_0000, wstrb: 4'h0};

  ebw_st_s st_q;
  ebw_st_s st_d;

  logic rdy_base;
  logic rdy_async;
  logic [15:0] din_s;

  // ****************************************
  // input synchronizers
  // ****************************************
  ebw_sync #(.WIDTH(1), .STAGES(2)) u_rdy_pin (
    .aclk(aclk), .aresetn(aresetn), .ce(ce), .din(ext_ready), .dout(rdy_base)
  );

  // extra two stages used only in asynchronous handshake mode
  ebw_sync #(.WIDTH(1), .STAGES(2)) u_rdy_async (
    .aclk(aclk), .aresetn(aresetn), .ce(ce), .din(rdy_base), .dout(rdy_async)
  );

  ebw_sync #(.WIDTH(16), .STAGES(2)) u_din (
    .aclk(aclk), .aresetn(aresetn), .ce(ce), .din(ext_din), .dout(din_s)
  );

  function automatic logic [15:0] wr16(logic [15:0] old, logic [31:0] d, logic [3:0] s);
    logic [15:0] r;
    r = old;
    if (s[0]) r[7:0] = d[7:0];
    if (s[1]) r[15:8] = d[15:8];
    return r;
  endfunction

  logic tick;
  logic async_mode;
  logic rdy_sel;
  logic rdy_act;
  logic e_done;
  logic cyc_end;

  assign async_mode = st_q.cfg[EBW_TIM_RDY_ASYNC];
  assign rdy_sel = async_mode ? rdy_async : rdy_base;
  assign rdy_act = rdy_sel ^ st_q.cfg[EBW_TIM_RDY_POL];
  assign tick = st_q.pins.reference_clock_output;
  assign e_done = st_q.cnt == st_q.cfg[EBW_TIM_E +: 5];

  always_comb begin
    st_d = st_q;
    cyc_end = 1'b0;
    // ****************************************
    // axi4-lite write path
    // ****************************************
    if (s_axi_awvalid && st_q.awready) begin
      st_d.aw_have = 1'b1;
      st_d.waddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && st_q.wready) begin
      st_d.w_have = 1'b1;
      st_d.wdat = s_axi_wdata;
      st_d.wstrb = s_axi_wstrb;
    end
    if (st_q.bvalid && s_axi_bready) begin
      st_d.bvalid = 1'b0;
    end
    if (st_q.aw_have && st_q.w_have && !st_q.bvalid) begin
      st_d.aw_have = 1'b0;
      st_d.w_have = 1'b0;
      st_d.bvalid = 1'b1;
      st_d.bresp = EBW_RESP_OKAY;
      unique case ({st_q.waddr[7:2], 2'b00})
        EBW_OFS_CTRL: begin
          if (st_q.wstrb[0]) begin
            st_d.ctl_rnw = st_q.wdat[EBW_CTRL_RNW];
            if (st_q.wdat[EBW_CTRL_START] && !st_q.go && st_q.ph == EBW_PH_IDLE) begin
              st_d.go = 1'b1;
            end
          end
        end
        EBW_OFS_STATUS: begin
          if (st_q.wstrb[0] && st_q.wdat[EBW_STAT_DONE]) begin
            st_d.done = 1'b0;
          end
        end
        EBW_OFS_ADDR: st_d.addr_r = wr16(st_q.addr_r, st_q.wdat, st_q.wstrb);
        EBW_OFS_WDATA: st_d.wdat_r = wr16(st_q.wdat_r, st_q.wdat, st_q.wstrb);
        EBW_OFS_TIMING: st_d.tim_r = wr16(st_q.tim_r, st_q.wdat, st_q.wstrb);
        EBW_OFS_RDATA: begin
        end
        default: st_d.bresp = EBW_RESP_SLVERR;
      endcase
    end
    st_d.awready = !st_d.aw_have && !st_d.bvalid;
    st_d.wready = !st_d.w_have && !st_d.bvalid;
    // ****************************************
    // axi4-lite read path
    // ****************************************
    if (st_q.rvalid && s_axi_rready) begin
      st_d.rvalid = 1'b0;
      st_d.arready = 1'b1;
    end
    if (s_axi_arvalid && st_q.arready) begin
      st_d.rvalid = 1'b1;
      st_d.arready = 1'b0;
      st_d.rresp = EBW_RESP_OKAY;
      st_d.rdata = 32'h0000_0000;
      unique case ({s_axi_araddr[7:2], 2'b00})
        EBW_OFS_CTRL: st_d.rdata[EBW_CTRL_RNW] = st_q.ctl_rnw;
        EBW_OFS_STATUS: begin
          st_d.rdata[EBW_STAT_BUSY] = st_q.go || st_q.ph != EBW_PH_IDLE;
          st_d.rdata[EBW_STAT_DONE] = st_q.done;
          st_d.rdata[EBW_STAT_WCNT +: 8] = st_q.wcnt;
        end
        EBW_OFS_ADDR: st_d.rdata[15:0] = st_q.addr_r;
        EBW_OFS_WDATA: st_d.rdata[15:0] = st_q.wdat_r;
        EBW_OFS_TIMING: st_d.rdata[15:0] = st_q.tim_r;
        EBW_OFS_RDATA: st_d.rdata[15:0] = st_q.rcap;
        default: st_d.rresp = EBW_RESP_SLVERR;
      endcase
    end
    // ****************************************
    // bus cycle sequencer, advances once per reference clock period
    // ****************************************
    st_d.pins.reference_clock_output = !st_q.pins.reference_clock_output;
    if (tick) begin
      st_d.cnt = st_q.cnt + 5'h01;
      unique case (st_q.ph)
        EBW_PH_IDLE: begin
          if (st_q.go) begin
            st_d.go = 1'b0;
            st_d.ph = EBW_PH_AB;
            st_d.cnt = 5'h00;
            st_d.wcnt = 8'h00;
            st_d.rnw = st_q.ctl_rnw;
            st_d.cfg = st_q.tim_r;
            st_d.pins.addr = st_q.addr_r;
            st_d.pins.dout = st_q.wdat_r;
          end
        end
        EBW_PH_AB: begin
          if (st_q.cnt[0] == st_q.cfg[EBW_TIM_AB]) begin
            st_d.cnt = 5'h00;
            if (st_q.cfg[EBW_TIM_C +: 2] != 2'h0) st_d.ph = EBW_PH_C;
            else if (st_q.cfg[EBW_TIM_D]) st_d.ph = EBW_PH_D;
            else st_d.ph = EBW_PH_E;
          end
        end
        EBW_PH_C: begin
          if (st_q.cnt[1:0] == st_q.cfg[EBW_TIM_C +: 2] - 2'h1) begin
            st_d.cnt = 5'h00;
            st_d.ph = st_q.cfg[EBW_TIM_D] ? EBW_PH_D : EBW_PH_E;
          end
        end
        EBW_PH_D: begin
          st_d.cnt = 5'h00;
          st_d.ph = EBW_PH_E;
        end
        EBW_PH_E: begin
          // handshake is looked at only once the programmed access units are over
          if (e_done) begin
            st_d.cnt = 5'h00;
            if (!st_q.cfg[EBW_TIM_RDY_EN]) begin
              cyc_end = 1'b1;
            end else if (async_mode) begin
              st_d.ph = EBW_PH_RDY;
              st_d.wcnt = 8'h01;
            end else if (rdy_act) begin
              cyc_end = 1'b1;
            end else begin
              st_d.ph = EBW_PH_RDY;
              st_d.wcnt = 8'h01;
            end
          end
        end
        EBW_PH_RDY: begin
          // responder must have withdrawn a stale handshake by now
          st_d.cnt = 5'h00;
          if (rdy_act) begin
            cyc_end = 1'b1;
          end else if (st_q.wcnt != 8'hFF) begin
            st_d.wcnt = st_q.wcnt + 8'h01;
          end
        end
        EBW_PH_F: begin
          if (st_q.cnt[1:0] == st_q.cfg[EBW_TIM_F +: 2] - 2'h1) begin
            st_d.ph = EBW_PH_IDLE;
            st_d.done = 1'b1;
          end
        end
      endcase
      if (cyc_end) begin
        if (st_q.rnw) begin
          st_d.rcap = din_s;
        end
        if (st_q.cfg[EBW_TIM_F +: 2] != 2'h0) begin
          st_d.ph = EBW_PH_F;
        end else begin
          st_d.ph = EBW_PH_IDLE;
          st_d.done = 1'b1;
        end
      end
    end
    // strobes follow the next phase so every pin leaves a flip-flop
    st_d.pins.cs_n = st_d.ph == EBW_PH_IDLE;
    st_d.pins.ale = st_d.ph == EBW_PH_AB;
    st_d.pins.rd_n = !(st_d.rnw && (st_d.ph == EBW_PH_E || st_d.ph == EBW_PH_RDY));
    st_d.pins.wr_n = !(!st_d.rnw && (st_d.ph == EBW_PH_E || st_d.ph == EBW_PH_RDY));
    st_d.pins.dout_oe = !st_d.rnw && (st_d.ph == EBW_PH_D || st_d.ph == EBW_PH_E ||
      st_d.ph == EBW_PH_RDY || st_d.ph == EBW_PH_F);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q <= ST_RST;
    end else if (ce) begin
      st_q <= st_d;
    end
  end

  assign s_axi_awready = st_q.awready;
  assign s_axi_wready = st_q.wready;
  assign s_axi_bvalid = st_q.bvalid;
  assign s_axi_bresp = st_q.bresp;
  assign s_axi_arready = st_q.arready;
  assign s_axi_rvalid = st_q.rvalid;
  assign s_axi_rresp = st_q.rresp;
  assign s_axi_rdata = st_q.rdata;
  assign ext_bus = st_q.pins;

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  logic samp;
  logic [6:0] e_cyc;
  assign samp = ce && tick && st_q.ph == EBW_PH_RDY;

  always_ff @(posedge aclk) begin
    if (!aresetn || st_q.ph != EBW_PH_E) begin
      e_cyc <= 7'h00;
    end else if (ce) begin
      e_cyc <= e_cyc + 7'h01;
    end
  end

  a_read_capture: assert property ($rose(st_q.pins.rd_n) |-> st_q.rcap == $past(din_s))
    else $error("read data not captured at read strobe end");
  a_addr_stable: assert property (!st_q.pins.rd_n && $past(!st_q.pins.rd_n) |->
    $stable(st_q.pins.addr))
    else $error("address moved while read strobe low");
  a_wait_insert: assert property (samp && !rdy_act |=> st_q.ph == EBW_PH_RDY)
    else $error("inactive handshake did not insert a wait state");
  a_ready_end: assert property (samp && rdy_act |=>
    st_q.ph == EBW_PH_F || st_q.ph == EBW_PH_IDLE)
    else $error("active handshake did not end the cycle");
  a_polarity_sel: assert property (samp && rdy_sel == st_q.cfg[EBW_TIM_RDY_POL] |=>
    st_q.ph == EBW_PH_RDY && st_q.pins.cs_n == 1'b0)
    else $error("handshake polarity not honoured");
  a_stretch_strobe: assert property (samp && !rdy_act && st_q.rnw |=>
    st_q.pins.rd_n == 1'b0)
    else $error("read strobe not extended by handshake");
  a_async_wait: assert property ($rose(st_q.ph == EBW_PH_RDY) && async_mode |->
    st_q.wcnt == 8'h01 ##0 st_q.ph == EBW_PH_RDY [*2])
    else $error("asynchronous mode skipped its wait state");
  a_sample_point: assert property ($rose(st_q.ph == EBW_PH_RDY) |->
    $past(st_q.cnt) == $past(st_q.cfg[EBW_TIM_E +: 5]))
    else $error("handshake sampled before access units elapsed");
  a_access_len: assert property ($fell(st_q.ph == EBW_PH_E) |->
    e_cyc == {st_q.cfg[EBW_TIM_E +: 5], 1'b1} + 7'h01)
    else $error("access phase length wrong");
  a_sync_fast: assert property ($fell(st_q.ph == EBW_PH_E) && !async_mode &&
    st_q.ph != EBW_PH_RDY |-> st_q.wcnt == 8'h00)
    else $error("synchronous ready cycle carries a wait state");

  c_read_wait: cover property ($rose(st_q.pins.rd_n) && st_q.wcnt > 8'h01);
  c_write_cycle: cover property ($rose(st_q.pins.wr_n));
  c_async_cycle: cover property (async_mode && st_q.cfg[EBW_TIM_RDY_EN] && samp && rdy_act);
  c_hold_phase: cover property (st_q.ph == EBW_PH_F);

endmodule

// ===== tb/ebw_mem_model.sv
module ebw_mem_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire ebw_pkg::ebw_pins_s ext_bus,
  input wire logic pol_low,
  input wire logic [15:0] dly,
  output logic ext_ready,
  output logic [15:0] ext_din,
  output logic [15:0] wr_data
);
  timeunit 1ns;
  timeprecision 1ns;
  import ebw_pkg::*;

  // ****************************************
  // responder handshake and data
  // ****************************************
  logic [15:0] cnt_q;
  logic seen_q;
  logic act_q;
  logic ended;

  assign ended = seen_q && ext_bus.rd_n && ext_bus.wr_n;
  // ready moves only on aclk, in step with the reference clock
  assign ext_ready = pol_low ? !act_q : act_q;

  always_ff @(posedge aclk) begin
    if (!aresetn || ext_bus.cs_n) begin
      cnt_q <= 16'h0000;
      seen_q <= 1'b0;
      act_q <= 1'b0;
    end else begin
      cnt_q <= cnt_q + 16'h0001;
      seen_q <= seen_q || !ext_bus.rd_n || !ext_bus.wr_n;
      // active from the chosen cycle until the strobe trailing edge
      act_q <= (cnt_q + 16'h0001 >= dly) && !ended;
    end
  end

  // data valid while selected, a changing pattern once the strobe has ended
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ext_din <= 16'h0000;
    end else if (!ext_bus.cs_n && !ended) begin
      ext_din <= ext_bus.addr ^ 16'h5A5A;
    end else begin
      ext_din <= ~ext_din;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_data <= 16'h0000;
    end else if (!ext_bus.wr_n && ext_bus.dout_oe) begin
      wr_data <= ext_bus.dout;
    end
  end
endmodule

// ===== tb/tb_ext_bus_ready_waitstate_ctrl.sv
module tb_ext_bus_ready_waitstate_ctrl;
  timeunit 1ns;
  timeprecision 1ns;
  import ebw_pkg::*;

  typedef struct packed {
    logic rnw; logic [1:0] c; logic d; logic [4:0] e; logic [1:0] f; logic ab;
    logic en; logic pol; logic asy; logic [7:0] w;
  } ebw_row_s;

  // ****************************************
  // signals and instances
  // ****************************************
  logic aclk, aresetn, ce, awvalid, wvalid, bready, arvalid, rready, awready, wready;
  logic bvalid, arready, rvalid, ext_ready, mem_pol;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [1:0] bresp, rresp;
  logic [15:0] ext_din, mem_dly, mem_wr;
  ebw_pins_s ext_bus;
  int error_cnt, checks, cyc, low_cnt;
  ebw_row_s rows [8] = '{
    '{1'b1, 2'h0, 1'b0, 5'h00, 2'h0, 1'b0, 1'b1, 1'b0, 1'b0, 8'h00},
    '{1'b1, 2'h0, 1'b0, 5'h00, 2'h1, 1'b1, 1'b1, 1'b1, 1'b0, 8'h02},
    '{1'b0, 2'h2, 1'b1, 5'h03, 2'h3, 1'b1, 1'b1, 1'b1, 1'b0, 8'h01},
    '{1'b1, 2'h1, 1'b0, 5'h1F, 2'h0, 1'b0, 1'b1, 1'b0, 1'b0, 8'h00},
    '{1'b1, 2'h0, 1'b0, 5'h00, 2'h0, 1'b0, 1'b1, 1'b0, 1'b1, 8'h00},
    '{1'b0, 2'h0, 1'b0, 5'h01, 2'h2, 1'b0, 1'b1, 1'b1, 1'b1, 8'h02},
    '{1'b1, 2'h0, 1'b0, 5'h02, 2'h0, 1'b0, 1'b0, 1'b0, 1'b0, 8'h00},
    '{1'b0, 2'h3, 1'b0, 5'h00, 2'h0, 1'b0, 1'b1, 1'b0, 1'b0, 8'h03}};

  ebw_ctrl i_dut (.aclk(aclk), .aresetn(aresetn), .ce(ce), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .ext_ready(ext_ready), .ext_din(ext_din), .ext_bus(ext_bus));

  ebw_mem_model i_mem (.aclk(aclk), .aresetn(aresetn), .ext_bus(ext_bus), .pol_low(mem_pol),
    .dly(mem_dly), .ext_ready(ext_ready), .ext_din(ext_din), .wr_data(mem_wr));

  always #50 aclk = ~aclk;

  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (!ext_bus.rd_n || !ext_bus.wr_n) begin
      low_cnt <= low_cnt + 1;
    end
    if (cyc == 30000) begin
      error_cnt++;
      summarize();
    end
  end

  // ****************************************
  // tasks
  // ****************************************
  task automatic summarize();
    $display("checks %0d error_cnt %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw_d, w_d;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    aw_d = 1'b0;
    w_d = 1'b0;
    forever begin
      @(posedge aclk);
      if (!aw_d && awready === 1'b1) begin
        aw_d = 1'b1;
        awvalid <= 1'b0;
      end
      if (!w_d && wready === 1'b1) begin
        w_d = 1'b1;
        wvalid <= 1'b0;
      end
      if (bvalid === 1'b1) break;
    end
    r = bresp;
    bready <= 1'b0;
  endtask

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ar_d;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    ar_d = 1'b0;
    forever begin
      @(posedge aclk);
      if (!ar_d && arready === 1'b1) begin
        ar_d = 1'b1;
        arvalid <= 1'b0;
      end
      if (rvalid === 1'b1) break;
    end
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] r;
    axi_wr(a, d, r);
    chk("write response", {30'h0, EBW_RESP_OKAY}, {30'h0, r});
  endtask

  task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] v;
    logic [1:0] r;
    axi_rd(a, v, r);
    chk(nm, exp, v);
  endtask

  task automatic run(input ebw_row_s r, input int i);
    logic [15:0] ad, tm;
    logic [31:0] v, wc;
    logic [1:0] rs;
    int s, lo0, n;
    ad = 16'h3C00 + 16'(i);
    tm = 16'(r.ab) | (16'(r.c) << EBW_TIM_C) | (16'(r.d) << EBW_TIM_D);
    tm = tm | (16'(r.e) << EBW_TIM_E) | (16'(r.f) << EBW_TIM_F) | (16'(r.en) << EBW_TIM_RDY_EN);
    tm = tm | (16'(r.pol) << EBW_TIM_RDY_POL) | (16'(r.asy) << EBW_TIM_RDY_ASYNC);
    s = 2 * (r.ab + 1 + r.c + r.d + r.e + 1 + r.w);
    mem_dly <= r.en ? 16'(s - 3) : 16'hFFFF;
    mem_pol <= r.pol;
    wr(EBW_OFS_ADDR, {16'h0, ad});
    wr(EBW_OFS_WDATA, {16'h0, ~ad});
    wr(EBW_OFS_TIMING, {16'h0, tm});
    lo0 = low_cnt;
    wr(EBW_OFS_CTRL, {30'h0, r.rnw, 1'b1});
    n = 0;
    do begin
      axi_rd(EBW_OFS_STATUS, v, rs);
      n++;
    end while (v[EBW_STAT_DONE] !== 1'b1 && n < 100);
    chk("done flag", 32'h1, {31'h0, v[EBW_STAT_DONE]});
    chk("busy after done", 32'h0, {31'h0, v[EBW_STAT_BUSY]});
    wc = {24'h0, v[15:8]};
    if (!r.en) begin
      chk("wait count", 32'h0, wc);
    end else if (!r.asy) begin
      chk("wait count", {24'h0, r.w}, wc);
    end else begin
      chk("async wait count in range", 32'h1, {31'h0, wc >= 1 && wc >= r.w && wc <= r.w + 3});
    end
    chk("strobe low cycles", 32'(2 * (r.e + 1 + wc)), 32'(low_cnt - lo0));
    if (r.rnw) begin
      rd_chk("read data", EBW_OFS_RDATA, {16'h0, ad ^ 16'h5A5A});
    end else begin
      chk("written data", {16'h0, ~ad}, {16'h0, mem_wr});
    end
    wr(EBW_OFS_STATUS, 32'h2);
    // wait count of the last cycle stays readable after done is cleared
    rd_chk("done cleared", EBW_OFS_STATUS, {16'h0, wc[7:0], 8'h00});
  endtask

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    logic [31:0] v;
    logic [1:0] rs;
    ebw_pins_s pins_frz;
    aclk = 1'b0;
    aresetn = 1'b0;
    ce = 1'b1;
    {awvalid, wvalid, bready, arvalid, rready, mem_pol} = 6'h00;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0;
    mem_dly = 16'hFFFF;
    error_cnt = 0;
    checks = 0;
    cyc = 0;
    low_cnt = 0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    chk("idle chip select", 32'h1, {31'h0, ext_bus.cs_n});
    rd_chk("timing reset", EBW_OFS_TIMING, {16'h0, EBW_TIMING_RST});
    rd_chk("addr reset", EBW_OFS_ADDR, {16'h0, EBW_ADDR_RST});
    rd_chk("status reset", EBW_OFS_STATUS, 32'h0);
    for (int i = 0; i < 8; i++) begin
      run(rows[i], i);
    end
    axi_rd(8'h18, v, rs);
    chk("unmapped read response", {30'h0, EBW_RESP_SLVERR}, {30'h0, rs});
    chk("unmapped read data", 32'h0, v);
    axi_wr(8'hFC, 32'h1, rs);
    chk("unmapped write response", {30'h0, EBW_RESP_SLVERR}, {30'h0, rs});
    // reset in the middle of a long read cycle
    mem_dly <= 16'hFFFF;
    wr(EBW_OFS_TIMING, 32'h1F0 | 32'h800);
    wr(EBW_OFS_CTRL, 32'h3);
    repeat (20) @(posedge aclk);
    chk("strobe low mid cycle", 32'h0, {31'h0, ext_bus.rd_n});
    // clock enable low must freeze every pin, reference clock included
    ce <= 1'b0;
    @(posedge aclk);
    pins_frz = ext_bus;
    repeat (3) @(posedge aclk);
    chk("frozen bus", 32'h1, {31'h0, ext_bus === pins_frz});
    ce <= 1'b1;
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk("strobe after reset", 32'h1, {31'h0, ext_bus.rd_n});
    chk("select after reset", 32'h1, {31'h0, ext_bus.cs_n});
    rd_chk("status after reset", EBW_OFS_STATUS, 32'h0);
    rd_chk("timing after reset", EBW_OFS_TIMING, {16'h0, EBW_TIMING_RST});
    summarize();
  end
endmodule
